// >>> rtl/fl_ctrl_regs.sv
/*
  Control and status registers of an LED flash driver: duration timer,
  mode selection, sink enable, strobe handling and fault flags.
  Assumes a serial bus front end that presents decoded register
  reads and writes as one-cycle strobes, and analog detectors and
  pins that are asynchronous to clk_in.
*/
`default_nettype none
module fl_ctrl_regs
  import fl_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS // Shorten in simulation
) (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic [3:0] reg_addr_in,    // Register offset
  input  wire logic [7:0] reg_wdata_in,   // Write data
  input  wire logic       reg_wr_in,      // Write strobe
  input  wire logic       reg_rd_in,      // Read strobe
  output logic      [7:0] reg_rdata_out,  // Read data, next cycle
  input  wire logic [7:0] led_current_in, // Current setting
  input  wire logic [1:0] pin_func_in,    // Mask/torch pin function
  input  wire logic [1:0] ind_duty_in,    // Indicator duty
  input  wire logic       strobe_in,      // Strobe pin
  input  wire logic       txmask_in,      // Mask/torch pin
  input  wire logic       uvlo_in,        // Undervoltage detector
  input  wire logic       overtemp_in,    // Temperature detector
  input  wire logic       led_short_in,   // Short detector
  input  wire logic       ovp_in,         // Overvoltage detector
  output logic            sink_outputs_en_out, // Sinks on
  output logic      [7:0] sink_current_out,    // Current code
  output logic            flash_active_out     // Flash pulse running
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] meta_q; // First stage, read only by sync_q
  logic [5:0] sync_q; // Safe copies
  always_ff @(posedge clk_in) begin
    meta_q <= {ovp_in, led_short_in, overtemp_in, uvlo_in,
               txmask_in, strobe_in};
    sync_q <= meta_q;
  end
  logic strobe_s, txm_s, strobe_d1_q;
  assign strobe_s = sync_q[0];
  assign txm_s    = sync_q[1];

  // Previous strobe level for edge sensing
  always_ff @(posedge clk_in) begin
    strobe_d1_q <= srst_in ? 1'b0 : strobe_s;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] dur_q;   // Duration code
  fl_mode_t   mode_q;  // Operating mode
  logic       out_on_q;
  logic       trig_on_q, trig_lvl_q;
  logic [7:0] fault_q;
  logic [7:0] fault_set; // Events this cycle
  logic       flash_end; // Pulse done, auto clear
  logic       wr_dur, wr_ctrl, wr_trig, rd_fault;

  assign wr_dur   = reg_wr_in && reg_addr_in == ADDR_DUR;
  assign wr_ctrl  = reg_wr_in && reg_addr_in == ADDR_CTRL;
  assign wr_trig  = reg_wr_in && reg_addr_in == ADDR_TRIG;
  assign rd_fault = reg_rd_in && reg_addr_in == ADDR_FAULT;

  // Duration code for the one timer that sets both flash length and timeout
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dur_q <= DUR_RST;
    end else if (wr_dur) begin
      dur_q <= reg_wdata_in;
    end
  end

  // Control: a host write wins over the auto clear in the same cycle
  // Bit 2 is not stored; the host keeps it zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_q   <= fl_mode_t'(CTRL_RST[1:0]);
      out_on_q <= CTRL_RST[CTRL_OUT_ON];
    end else if (wr_ctrl) begin
      mode_q   <= fl_mode_t'(reg_wdata_in[1:0]);
      out_on_q <= reg_wdata_in[CTRL_OUT_ON];
    end else if (flash_end) begin
      mode_q   <= MODE_OFF;
      out_on_q <= 1'b0;
    end
  end

  // Strobe configuration
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      trig_on_q  <= TRIG_RST[TRIG_ON];
      trig_lvl_q <= TRIG_RST[TRIG_TYPE];
    end else if (wr_trig) begin
      trig_on_q  <= reg_wdata_in[TRIG_ON];
      trig_lvl_q <= reg_wdata_in[TRIG_TYPE];
    end
  end

  // ----------------------------------------------------------------
  // Flash sequencer
  // ----------------------------------------------------------------
  typedef enum logic {FL_IDLE, FL_ON} fl_state_t;
  fl_state_t st_q;
  logic armed, start, expire, lvl_end;

  assign armed = mode_q == MODE_FLASH && out_on_q;
  // Disabled strobe: flash fires as soon as it is armed
  always_comb begin
    start = 1'b0;
    // Mode is still flash while the auto clear is pending: no restart
    if (st_q == FL_IDLE && armed && !flash_end) begin
      if (!trig_on_q) begin
        start = 1'b1;
      end else if (trig_lvl_q) begin
        start = strobe_s;
      end else begin
        start = strobe_s && !strobe_d1_q;
      end
    end
  end
  // Level sensing ends when the strobe drops
  assign lvl_end = trig_on_q && trig_lvl_q && !strobe_s;

  fl_ms_timer #(.CYC_MS(CYC_MS)) u_tmr (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .start_in  (start),
    .stop_in   (st_q == FL_ON && (lvl_end || !armed)),
    .dur_ms_in (dur_ms(dur_q)),
    .expire_out(expire)
  );

  // One pulse per arming; ending clears the arming
  always_ff @(posedge clk_in) begin
    flash_end <= 1'b0;
    if (srst_in) begin
      st_q <= FL_IDLE;
    end else begin
      case (st_q)
        FL_IDLE: begin
          if (start) begin
            st_q <= FL_ON;
          end
        end
        FL_ON: begin
          if (!armed) begin
            st_q <= FL_IDLE; // Host aborted
          end else if (expire || lvl_end) begin
            st_q      <= FL_IDLE;
            flash_end <= 1'b1;
          end
        end
        default: st_q <= FL_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fault flags: set wins over the read clear
  // ----------------------------------------------------------------
  logic flash_on, tmo_hit;
  assign flash_on = st_q == FL_ON;
  // Timeout: the strobe still asks for light when time runs out
  assign tmo_hit = flash_on && expire && trig_on_q && trig_lvl_q
                   && strobe_s;
  always_comb begin
    fault_set            = 8'h00;
    fault_set[FLT_UVLO]  = sync_q[2];
    fault_set[FLT_TXM]   = flash_on && txm_s
                           && pin_func_in == PF_TXMASK;
    fault_set[FLT_TMO]   = tmo_hit;
    fault_set[FLT_OTP]   = sync_q[3];
    fault_set[FLT_SHORT] = sync_q[4];
    fault_set[FLT_OVP]   = sync_q[5];
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fault_q <= FLT_RST;
    end else begin
      fault_q <= (rd_fault ? 8'h00 : fault_q) | fault_set;
    end
  end

  // Read data; unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_DUR:   reg_rdata_out <= dur_q;
        ADDR_CTRL:  reg_rdata_out <= {4'h0, out_on_q, 1'b0, mode_q};
        ADDR_TRIG:  reg_rdata_out <= {trig_on_q, trig_lvl_q, 6'h00};
        ADDR_FAULT: reg_rdata_out <= fault_q;
        default:    reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sink drive
  // ----------------------------------------------------------------
  logic pwm_on, torch_req;
  fl_pwm u_pwm (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .duty_in   (ind_duty_in),
    .pwm_on_out(pwm_on)
  );
  assign torch_req = pin_func_in == PF_TORCH && txm_s;

  // Current code and enable per mode
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sink_current_out    <= 8'h00;
      sink_outputs_en_out <= 1'b0;
    end else begin
      sink_current_out    <= 8'h00;
      sink_outputs_en_out <= 1'b0;
      case (mode_q)
        MODE_OFF: begin
          if (torch_req) begin
            sink_current_out    <= led_current_in & 8'h7f;
            sink_outputs_en_out <= 1'b1;
          end
        end
        MODE_IND: begin
          sink_current_out    <= led_current_in & 8'h3f;
          sink_outputs_en_out <= out_on_q && pwm_on;
        end
        MODE_ASSIST: begin
          sink_current_out    <= led_current_in & 8'h7f;
          sink_outputs_en_out <= out_on_q;
        end
        MODE_FLASH: begin
          sink_current_out    <= led_current_in;
          sink_outputs_en_out <= flash_on && armed;
        end
        default: sink_current_out <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    flash_active_out <= srst_in ? 1'b0 : flash_on;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  // A host write in the auto clear cycle wins, so only a bare end counts
  sequence s_flash_done;
    flash_end && !wr_ctrl;
  endsequence

  a_fault_rd_clr: assert property (
    rd_fault && fault_set == 8'h00 |=> fault_q == 8'h00)
    else $error("fault flags not cleared by read");
  a_fault_set_win: assert property (
    fault_set[FLT_OVP] |=> fault_q[FLT_OVP])
    else $error("fault event lost");
  a_flash_autoclr: assert property (
    s_flash_done |=> mode_q == MODE_OFF && !out_on_q)
    else $error("flash end did not clear mode");
  a_sink_off: assert property (
    !out_on_q && mode_q != MODE_OFF |=> !sink_outputs_en_out)
    else $error("sink on while disabled");
  a_assist_msb: assert property (
    mode_q == MODE_ASSIST && !wr_ctrl |=> !sink_current_out[7])
    else $error("assist uses top current bit");
  a_ind_mask: assert property (
    mode_q == MODE_IND && !wr_ctrl |=> sink_current_out[7:6] == 2'h0)
    else $error("indicator uses high current bits");
  a_shut_off: assert property (
    mode_q == MODE_OFF && !torch_req |=> sink_current_out == 8'h00
    && !sink_outputs_en_out)
    else $error("shutdown drives sink");
  a_torch_pin: assert property (
    mode_q == MODE_OFF && torch_req && !wr_ctrl |=> sink_outputs_en_out)
    else $error("torch pin ignored");
  a_timeout_flag: assert property (
    tmo_hit |=> fault_q[FLT_TMO] ##1 !flash_on)
    else $error("timeout not flagged");
  a_edge_start: assert property (
    st_q == FL_IDLE && armed && !flash_end && trig_on_q && !trig_lvl_q
    && strobe_s && !strobe_d1_q |=> flash_on)
    else $error("edge did not start flash");
endmodule
`default_nettype wire

// >>> rtl/fl_ms_timer.sv
/*
  Millisecond duration timer for one flash pulse.
  Assumes a start pulse and a duration in ms from the same clock.
*/
`default_nettype none
module fl_ms_timer
  import fl_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        start_in,   // Load and run
  input  wire logic        stop_in,    // Abort
  input  wire logic [10:0] dur_ms_in,  // Duration in ms
  output logic             expire_out  // One-cycle pulse at end
);
  // ----------------------------------------------------------------
  // Divider and ms counter
  // ----------------------------------------------------------------
  logic [15:0] div_q;  // Cycles within the current ms
  logic [10:0] ms_q;   // Milliseconds left
  logic        run_q;  // Counting

  // Expiry shows in the last counted cycle, not one later, so the
  // pulse lasts exactly the programmed number of milliseconds
  assign expire_out = run_q && div_q == 16'(CYC_MS - 1) && ms_q == 11'h001;

  // The ms tick is a local enable, so no second clock is needed
  always_ff @(posedge clk_in) begin
    if (srst_in || stop_in) begin
      run_q <= 1'b0;
      div_q <= 16'h0000;
      ms_q  <= 11'h000;
    end else if (start_in) begin
      run_q <= 1'b1;
      div_q <= 16'h0000;
      ms_q  <= dur_ms_in;
    end else if (run_q) begin
      if (div_q == 16'(CYC_MS - 1)) begin
        div_q <= 16'h0000;
        if (ms_q == 11'h001) begin
          run_q <= 1'b0;
        end else begin
          ms_q <= ms_q - 11'h001;
        end
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/fl_pwm.sv
/*
  Indicator PWM at 31.25 kHz with 1/16..4/16 duty.
  Assumes the 10 MHz system clock.
*/
`default_nettype none
module fl_pwm
  import fl_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic [1:0] duty_in,    // 00 = 1/16 .. 11 = 4/16
  output logic            pwm_on_out  // High during the on slice
);
  logic [8:0] cnt_q;  // Position in the period
  logic [8:0] on_len; // On cycles for this duty

  // Period counter
  always_ff @(posedge clk_in) begin
    if (srst_in || cnt_q == 9'(PWM_PERIOD - 1)) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  assign on_len = 9'(({7'h00, duty_in} + 9'h001) * PWM_SLOT);

  // Registered output keeps the sink gate glitch free
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pwm_on_out <= 1'b0;
    end else begin
      pwm_on_out <= cnt_q < on_len;
    end
  end
endmodule
`default_nettype wire

// >>> shared/fl_pkg.sv
/*
  Shared constants for the flash LED control block: register offsets,
  field positions, reset values, mode codes and timing counts.
  Assumes a 10 MHz system clock.
*/
`default_nettype none
package fl_pkg;
  // ----------------------------------------------------------------
  // Register offsets on the serial register port
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_DUR   = 4'h5; // Pulse duration limit
  localparam logic [3:0] ADDR_CTRL  = 4'h6; // Operating control
  localparam logic [3:0] ADDR_TRIG  = 4'h7; // Trigger input config
  localparam logic [3:0] ADDR_FAULT = 4'h8; // Protection flags

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DUR_RST  = 8'h23;  // 72 ms
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'hc0;  // Enabled, level sensed
  localparam logic [7:0] FLT_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OUT_ON = 3; // Sink enable
  localparam int TRIG_TYPE   = 6; // 1 = level, 0 = edge
  localparam int TRIG_ON     = 7; // Strobe enable
  localparam int FLT_UVLO    = 0;
  localparam int FLT_TXM     = 3;
  localparam int FLT_TMO     = 4;
  localparam int FLT_OTP     = 5;
  localparam int FLT_SHORT   = 6;
  localparam int FLT_OVP     = 7;

  // Pin-function settings of the transmit-mask/torch pin
  localparam logic [1:0] PF_TXMASK = 2'h1;
  localparam logic [1:0] PF_TORCH  = 2'h2;

  // Operating modes, in field order 00..11
  typedef enum logic [1:0] {
    MODE_OFF, MODE_IND, MODE_ASSIST, MODE_FLASH
  } fl_mode_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 10_000_000;
  localparam int TICK_MS     = 1;                       // Timer step
  localparam int CYC_PER_MS  = CLK_HZ / 1000 * TICK_MS; // 10000
  localparam int PWM_FREQ_HZ = 31_250;
  localparam int PWM_PERIOD  = CLK_HZ / PWM_FREQ_HZ;    // 320
  localparam int PWM_SLOTS   = 16;
  localparam int PWM_SLOT    = PWM_PERIOD / PWM_SLOTS;  // 20

  // Duration code to milliseconds, 2 ms steps then 8 ms steps
  function automatic logic [10:0] dur_ms(input logic [7:0] c);
    logic [7:0] hi;
    hi = c - 8'h7f;
    if (c < 8'h80) begin
      dur_ms = {2'h0, c, 1'b0} + 11'h002;
    end else begin
      dur_ms = {hi, 3'h0} + 11'h100;
    end
  endfunction
endpackage
`default_nettype wire

// >>> tb/fl_host_model.sv
/*
  Host model: issues decoded register writes and reads as one-cycle
  strobes. Assumes it shares clk_in with the block.
*/
`default_nettype none
module fl_host_model
  import fl_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [3:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Idle bus at time zero
  // ------------------------------------------------------------
  initial begin
    addr_out  = 4'h0;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // One write strobe; the block takes it at the following edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= (a == ADDR_CTRL) ? (d & 8'hfb) : d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d; // Released data must not look valid
  endtask

  // Read strobe, then pick data up once it has settled
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask
endmodule
`default_nettype wire

// >>> tb/flash_led_control_regs_tb_top.sv
/*
  Testbench top for the flash LED control block.
  Assumes the host model owns the register port; pins are driven here.
*/
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module flash_led_control_regs_tb_top
  import fl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic       clk_in, srst_in, reg_wr, reg_rd, strobe, txmask, sink_en, fl_act;
  logic [3:0] reg_addr, det;   // det: uvlo, overtemp, short, ovp
  logic [7:0] reg_wdata, rdata, cur, sink_cur, rv;
  logic [1:0] pin_func, duty;
  int         errors, check_count;

  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Short millisecond so long codes stay cheap to run
  fl_ctrl_regs #(.CYC_MS(10)) u_fl_ctrl_regs (
    .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .led_current_in(cur), .pin_func_in(pin_func),
    .ind_duty_in(duty), .strobe_in(strobe), .txmask_in(txmask),
    .uvlo_in(det[0]), .overtemp_in(det[1]), .led_short_in(det[2]),
    .ovp_in(det[3]), .sink_outputs_en_out(sink_en),
    .sink_current_out(sink_cur), .flash_active_out(fl_act));

  fl_host_model u_fl_host_model (
    .clk_in(clk_in), .rdata_in(rdata), .addr_out(reg_addr),
    .wdata_out(reg_wdata), .wr_out(reg_wr), .rd_out(reg_rd));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask

  task automatic w(input logic [3:0] a, input logic [7:0] d);
    u_fl_host_model.wr(a, d);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    u_fl_host_model.rd(a, rv);
    `CHK(rv, e)
  endtask

  // Strobe pin high for k cycles
  task automatic pulse(input int k);
    @(posedge clk_in);
    strobe <= 1'b1;
    repeat (k) @(posedge clk_in);
    strobe <= 1'b0;
  endtask

  // Length of the next flash; zero if none starts within 100 cycles
  task automatic flen(output int n, output logic [7:0] fc, output logic fe);
    int i;
    n  = 0;
    fc = 8'h00;
    fe = 1'b0;
    for (i = 0; i < 100 && fl_act !== 1'b1; i++) tick();
    if (fl_act === 1'b1) begin
      fc = sink_cur;
      fe = sink_en;
    end
    while (fl_act === 1'b1 && n < 5000) begin
      tick();
      n++;
    end
  endtask

  // Expected flash length in cycles, 10 cycles a millisecond
  function automatic int exp_cyc(input int c);
    return ((c < 128) ? (c + 1) * 2 : (c - 127) * 8 + 256) * 10;
  endfunction

  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: whole run needs about 10000 cycles
  initial begin
    repeat (30000) @(posedge clk_in);
    errors++;
    final_report();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] codes [4];
    logic [7:0] fbit  [4];
    logic [7:0] fc;
    logic       fe;
    int         i, n;
    codes    = '{8'h00, 8'h01, 8'h80, 8'h81};
    fbit     = '{8'h01, 8'h20, 8'h40, 8'h80};
    srst_in  = 1'b1;
    strobe   = 1'b0;
    txmask   = 1'b0;
    det      = 4'h0;
    cur      = 8'he5; // Top bit set so the masks show
    pin_func = 2'h0;
    duty     = 2'h0;
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    // Reset values, access kinds, unmapped offset
    rchk(ADDR_DUR, 8'h23);
    rchk(ADDR_CTRL, 8'h00);
    rchk(ADDR_TRIG, 8'hc0);
    rchk(ADDR_FAULT, 8'h00);
    w(4'h3, 8'hff);
    rchk(4'h3, 8'h00);
    w(ADDR_DUR, 8'h5a);
    rchk(ADDR_DUR, 8'h5a);
    w(ADDR_CTRL, 8'hf2);
    rchk(ADDR_CTRL, 8'h02);
    w(ADDR_TRIG, 8'hff);
    rchk(ADDR_TRIG, 8'hc0);
    w(ADDR_FAULT, 8'hff);
    rchk(ADDR_FAULT, 8'h00);
    w(ADDR_CTRL, 8'h00);
    // Timed flashes, strobe disabled, both step sizes
    w(ADDR_TRIG, 8'h00);
    for (i = 0; i < 4; i++) begin
      w(ADDR_DUR, codes[i]);
      w(ADDR_CTRL, 8'h0b);
      flen(n, fc, fe);
      `CHK(n, exp_cyc(codes[i]))
      `CHK(fc, cur)
      `CHK(fe, 1'b1)
      rchk(ADDR_CTRL, 8'h00);
      `CHK(sink_en, 1'b0)
    end
    // Level strobe: pulse follows the pin, then runs into the timer
    w(ADDR_DUR, 8'h00);
    w(ADDR_TRIG, 8'hc0);
    w(ADDR_CTRL, 8'h0b);
    fork pulse(8); flen(n, fc, fe); join
    `CHK(n inside {[7:9]}, 1'b1)
    w(ADDR_CTRL, 8'h0b);
    fork pulse(40); flen(n, fc, fe); join
    `CHK(n, 20)
    rchk(ADDR_FAULT, 8'h10);
    rchk(ADDR_FAULT, 8'h00);
    // Edge strobe: short pulse still gives a full timed flash
    w(ADDR_TRIG, 8'h80);
    w(ADDR_CTRL, 8'h0b);
    fork pulse(3); flen(n, fc, fe); join
    `CHK(n, 20)
    rchk(ADDR_FAULT, 8'h00);
    // Strobe outside flash mode is ignored; assist current
    w(ADDR_TRIG, 8'hc0);
    w(ADDR_CTRL, 8'h0a);
    fork pulse(10); flen(n, fc, fe); join
    `CHK(n, 0)
    `CHK(sink_cur, 8'h65)
    `CHK(sink_en, 1'b1)
    w(ADDR_CTRL, 8'h02);
    tick();
    tick();
    `CHK(sink_en, 1'b0)
    // Indicator duty over one full PWM period, every duty code
    w(ADDR_CTRL, 8'h09);
    for (i = 0; i < 4; i++) begin
      @(posedge clk_in);
      duty <= i[1:0];
      repeat (640) tick();
      n = 0;
      repeat (320) begin
        tick();
        n += int'(sink_en === 1'b1);
      end
      `CHK(n, (i + 1) * 20)
      `CHK(sink_cur, 8'h25)
    end
    // Pin-driven torch from shutdown, then pin function removed
    w(ADDR_CTRL, 8'h00);
    @(posedge clk_in);
    pin_func <= 2'h2;
    txmask   <= 1'b1;
    repeat (10) tick();
    `CHK(sink_en, 1'b1)
    `CHK(sink_cur, 8'h65)
    @(posedge clk_in);
    pin_func <= 2'h0;
    repeat (10) tick();
    `CHK(sink_en, 1'b0)
    @(posedge clk_in);
    txmask <= 1'b0;
    // Detector pulses one at a time, each cleared by its read
    for (i = 0; i < 4; i++) begin
      @(posedge clk_in);
      det <= 4'h1 << i;
      @(posedge clk_in);
      det <= 4'h0;
      repeat (5) tick();
      rchk(ADDR_FAULT, fbit[i]);
      rchk(ADDR_FAULT, 8'h00);
    end
    // Mask pin raised in mid-flash
    w(ADDR_TRIG, 8'h00);
    w(ADDR_DUR, 8'h01);
    @(posedge clk_in);
    pin_func <= 2'h1;
    w(ADDR_CTRL, 8'h0b);
    repeat (10) @(posedge clk_in);
    txmask <= 1'b1;
    repeat (5) @(posedge clk_in);
    txmask <= 1'b0;
    repeat (60) tick();
    rchk(ADDR_FAULT, 8'h08);
    rchk(ADDR_CTRL, 8'h00);
    final_report();
  end
endmodule
`undef CHK
`default_nettype wire
